// [ssu_consts.vh]
`ifndef SSU_CONSTS_VH
`define SSU_CONSTS_VH
// Contract
// - entry address is table base plus selector bits 15..3 times eight
// - long mode still scales index by eight; software aligns 16-byte entries
// - selector bit 2 clear picks global table base, set picks local table base
// - selector bits 1..0 carry requester privilege for later checks
// - index 0 with bit 2 clear is null; use outside 64-bit mode faults
// - null loads fault for code, and for stack outside 64-bit or at privilege 3
// - six 16-bit segment registers, codes 0 extra to 5 second auxiliary
// - every selector load fetches its entry into the hidden portion; here a null selector is stored with no fetch, hidden part kept
// - hidden portion unreachable by software except the two auxiliary bases
// - fetches use code segment; code load sets current privilege from entry
// - data uses default data; string targets use extra; stack uses stack
// - 64-bit code segment keeps long, size, privilege; base 0, canonical check
// - 64-bit extra, data, stack: base 0, no limits, canonical check only
// - mode changes never alter visible or hidden segment contents
// - 64-bit auxiliary override adds full 64-bit base, wrapping allowed
// - 64-bit auxiliary override checks canonical form only
// - ordinary auxiliary loads write 32-bit base and clear upper bits
// - auxiliary bases are model registers c0000100 and c0000101, privilege 0
// - non-canonical model register write to an auxiliary base faults
// - compatibility mode ignores upper 32 auxiliary base bits
// - outside 64-bit mode the upper table base bytes are ignored

// segment register codes
`define SSU_SEG_EXTRA 3'h0
`define SSU_SEG_CODE 3'h1
`define SSU_SEG_STACK 3'h2
`define SSU_SEG_DATA 3'h3
`define SSU_SEG_AUX1 3'h4
`define SSU_SEG_AUX2 3'h5
`define SSU_SEG_LTP 3'h6
`define SSU_SEG_LAST 3'h6
// selector fields
`define SSU_IDX_HI 15
`define SSU_IDX_LO 3
`define SSU_TSEL_BIT 2
`define SSU_RPL_HI 1
`define SSU_RPL_LO 0
// hidden attribute fields
`define SSU_ATTR_DPL_HI 6
`define SSU_ATTR_DPL_LO 5
`define SSU_ATTR_LONG 13
`define SSU_ATTR_DSIZE 14
// canonical form: bits 63..47 all equal
`define SSU_VA_MSB 47
// model register addresses
`define SSU_MSR_AUX1 32'hc000_0100
`define SSU_MSR_AUX2 32'hc000_0101
// access kinds
`define SSU_KIND_FETCH 2'h0
`define SSU_KIND_DATA 2'h1
`define SSU_KIND_STR 2'h2
`define SSU_KIND_STACK 2'h3
// fault codes
`define SSU_FLT_NONE 3'h0
`define SSU_FLT_NULL_LOAD 3'h1
`define SSU_FLT_NULL_REF 3'h2
`define SSU_FLT_LIMIT 3'h3
`define SSU_FLT_CANON 3'h4
`define SSU_FLT_MSR_PRIV 3'h5
`define SSU_FLT_MSR_CANON 3'h6
// reset values and user privilege
`define SSU_RST_SEL 16'h0000
`define SSU_RST_CPL 2'h0
`define SSU_PRIV_USER 2'h3
`endif

// [ssu_sel_decode.v]
`timescale 1ns/10ps
`include "ssu_consts.vh"
module ssu_sel_decode (
  // selector and mode
  input wire [15:0] sel,
  input wire in64,
  // table bases
  input wire [63:0] glob_base,
  input wire [63:0] loc_base,
  // decoded results
  output wire [63:0] entry_addr,
  output wire [1:0] requester_priv_level
);
  wire [63:0] tbl_base;
  wire [63:0] tbl_eff;
  // table pick by select bit
  assign tbl_base = sel[`SSU_TSEL_BIT] ? loc_base : glob_base;
  // upper base half dropped outside 64-bit mode
  assign tbl_eff = in64 ? tbl_base : {32'h0000_0000, tbl_base[31:0]};
  // index scaled by eight in every mode
  assign entry_addr = tbl_eff + {48'h0000_0000_0000, sel[`SSU_IDX_HI:`SSU_IDX_LO], 3'h0};
  assign requester_priv_level = sel[`SSU_RPL_HI:`SSU_RPL_LO];
endmodule // ssu_sel_decode

// [ssu_eff_addr.v]
`timescale 1ns/10ps
`include "ssu_consts.vh"
module ssu_eff_addr (
  // segment state
  input wire in64,
  input wire [2:0] seg,
  input wire [31:0] base_lo,
  input wire [31:0] base_hi,
  input wire [31:0] limit,
  input wire is_null,
  // offset from the pipeline
  input wire [63:0] offset,
  // results
  output reg [63:0] lin,
  output reg flt,
  output reg [2:0] code
);
  wire aux;
  assign aux = (seg == `SSU_SEG_AUX1) | (seg == `SSU_SEG_AUX2);
  // address and checks per mode
  always @* begin
    lin = 64'h0000_0000_0000_0000;
    flt = 1'b0;
    code = `SSU_FLT_NONE;
    if (in64) begin
      // only auxiliary bases count, 64-bit wrap allowed
      if (aux)
        lin = {base_hi, base_lo} + offset;
      else
        lin = offset;
      if (!((&lin[63:`SSU_VA_MSB]) | ~(|lin[63:`SSU_VA_MSB]))) begin
        flt = 1'b1;
        code = `SSU_FLT_CANON;
      end
    end else begin
      // upper base half ignored in legacy and compatibility
      lin = {32'h0000_0000, base_lo + offset[31:0]};
      if (is_null) begin
        flt = 1'b1;
        code = `SSU_FLT_NULL_REF;
      end else if (offset[31:0] > limit) begin
        flt = 1'b1;
        code = `SSU_FLT_LIMIT;
      end
    end
  end
endmodule // ssu_eff_addr

// [ssu_top.v]
`timescale 1ns/10ps
`include "ssu_consts.vh"
module ssu_top (
  // clock, reset, enable
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  // operating mode
  input wire long_act,
  // segment load request
  input wire ld_valid,
  input wire [2:0] ld_seg,
  input wire [15:0] ld_sel,
  output reg ld_busy,
  output reg ld_done,
  output reg [1:0] ld_rpl,
  // global table base
  input wire [63:0] glob_base,
  // descriptor fetch
  output reg dsc_req,
  output reg [63:0] dsc_addr,
  input wire dsc_ack,
  input wire [63:0] dsc_base,
  input wire [31:0] dsc_limit,
  input wire [15:0] dsc_attr,
  // memory access
  input wire acc_valid,
  input wire [1:0] acc_kind,
  input wire acc_ovr_en,
  input wire [2:0] acc_ovr_seg,
  input wire [63:0] acc_offset,
  output reg acc_done,
  output reg [63:0] acc_lin,
  output reg [1:0] acc_rpl,
  // model register port
  input wire msr_wr,
  input wire msr_rd,
  input wire [31:0] msr_addr,
  input wire [63:0] msr_wdata,
  output reg msr_done,
  output reg [63:0] msr_rdata,
  // status
  output reg [1:0] cur_cpl,
  output reg mode_64,
  output reg cs_long,
  output reg cs_dsize,
  // fault report
  output reg fault,
  output reg [2:0] fault_code
);
  // load sequencer states
  localparam ST_IDLE = 2'b01;
  localparam ST_FETCH = 2'b10;

  // visible and hidden parts, slot 6 is the local table pointer
  reg [15:0] sel_r [0:6];
  reg [31:0] blo [0:6];
  reg [31:0] bhi [0:6];
  reg [31:0] lim [0:6];
  reg [15:0] atr [0:6];

  reg [1:0] st;
  reg [2:0] ld_seg_q;
  reg [15:0] ld_sel_q;
  integer i;

  // null selector test, used for loads and accesses
  function is_null_sel;
    input [15:0] s;
    begin
      is_null_sel = ~(|s[`SSU_IDX_HI:`SSU_TSEL_BIT]);
    end
  endfunction

  // segment chosen for an access
  function [2:0] route_seg;
    input [1:0] kind;
    input ovr_en;
    input [2:0] ovr;
    begin
      case (kind)
        `SSU_KIND_FETCH: route_seg = `SSU_SEG_CODE;
        `SSU_KIND_STR: route_seg = `SSU_SEG_EXTRA;
        `SSU_KIND_STACK: route_seg = `SSU_SEG_STACK;
        default: begin
          if (ovr_en && ovr <= `SSU_SEG_AUX2)
            route_seg = ovr;
          else
            route_seg = `SSU_SEG_DATA;
        end
      endcase
    end
  endfunction

  // 64-bit mode needs long mode active and the code segment long bit
  wire in64;
  wire [15:0] cs_attr;
  assign cs_attr = atr[`SSU_SEG_CODE];
  assign in64 = long_act & cs_attr[`SSU_ATTR_LONG];

  // selector decode for loads
  wire [63:0] ld_entry;
  wire [1:0] ld_rpl_w;
  wire [63:0] loc_base;
  assign loc_base = {bhi[`SSU_SEG_LTP], blo[`SSU_SEG_LTP]};
  ssu_sel_decode u_dec (
    .sel(ld_sel),
    .in64(in64),
    .glob_base(glob_base),
    .loc_base(loc_base),
    .entry_addr(ld_entry),
    .requester_priv_level(ld_rpl_w)
  );

  // load admission
  wire ld_null;
  wire ld_bad;
  wire ld_take;
  assign ld_null = is_null_sel(ld_sel);
  assign ld_bad = (ld_seg > `SSU_SEG_LAST) |
    (ld_null & (ld_seg == `SSU_SEG_CODE)) |
    (ld_null & (ld_seg == `SSU_SEG_STACK) &
      (~in64 | (cur_cpl == `SSU_PRIV_USER)));
  assign ld_take = ld_valid & st[0];

  // access path
  wire [2:0] acc_seg;
  wire [63:0] acc_lin_w;
  wire acc_flt;
  wire [2:0] acc_code;
  assign acc_seg = route_seg(acc_kind, acc_ovr_en, acc_ovr_seg);
  ssu_eff_addr u_ea (
    .in64(in64),
    .seg(acc_seg),
    .base_lo(blo[acc_seg]),
    .base_hi(bhi[acc_seg]),
    .limit(lim[acc_seg]),
    .is_null(is_null_sel(sel_r[acc_seg])),
    .offset(acc_offset),
    .lin(acc_lin_w),
    .flt(acc_flt),
    .code(acc_code)
  );

  // model register decode and checks
  wire msr_hit1;
  wire msr_hit2;
  wire msr_any;
  wire msr_priv_bad;
  wire msr_canon_bad;
  wire msr_ok;
  assign msr_hit1 = (msr_addr == `SSU_MSR_AUX1);
  assign msr_hit2 = (msr_addr == `SSU_MSR_AUX2);
  assign msr_any = (msr_wr | msr_rd) & (msr_hit1 | msr_hit2);
  assign msr_priv_bad = msr_any & (cur_cpl != `SSU_RST_CPL);
  assign msr_canon_bad = msr_wr & (msr_hit1 | msr_hit2) & ~msr_priv_bad &
    ~((&msr_wdata[63:`SSU_VA_MSB]) | ~(|msr_wdata[63:`SSU_VA_MSB]));
  assign msr_ok = msr_wr & (msr_hit1 | msr_hit2) & ~msr_priv_bad & ~msr_canon_bad;

  // fault merge, load first then model register then access
  reg next_fault;
  reg [2:0] next_code;
  always @* begin
    next_fault = 1'b0;
    next_code = `SSU_FLT_NONE;
    if (ld_take && ld_bad) begin
      next_fault = 1'b1;
      next_code = `SSU_FLT_NULL_LOAD;
    end else if (msr_priv_bad) begin
      next_fault = 1'b1;
      next_code = `SSU_FLT_MSR_PRIV;
    end else if (msr_canon_bad) begin
      next_fault = 1'b1;
      next_code = `SSU_FLT_MSR_CANON;
    end else if (acc_valid && acc_flt) begin
      next_fault = 1'b1;
      next_code = acc_code;
    end
  end

  // all state, frozen outside reset while the enable is low
  always @(posedge clk) begin
    if (sys_rst) begin
      st <= ST_IDLE;
      ld_seg_q <= `SSU_SEG_EXTRA;
      ld_sel_q <= `SSU_RST_SEL;
      ld_busy <= 1'b0;
      ld_done <= 1'b0;
      ld_rpl <= 2'h0;
      dsc_req <= 1'b0;
      dsc_addr <= 64'h0000_0000_0000_0000;
      acc_done <= 1'b0;
      acc_lin <= 64'h0000_0000_0000_0000;
      acc_rpl <= 2'h0;
      msr_done <= 1'b0;
      msr_rdata <= 64'h0000_0000_0000_0000;
      cur_cpl <= `SSU_RST_CPL;
      mode_64 <= 1'b0;
      cs_long <= 1'b0;
      cs_dsize <= 1'b0;
      fault <= 1'b0;
      fault_code <= `SSU_FLT_NONE;
      for (i = 0; i < 7; i = i + 1) begin
        sel_r[i] <= `SSU_RST_SEL;
        blo[i] <= 32'h0000_0000;
        bhi[i] <= 32'h0000_0000;
        lim[i] <= 32'h0000_0000;
        atr[i] <= 16'h0000;
      end
    end else if (clk_en) begin
      // one-cycle answers
      ld_done <= 1'b0;
      fault <= next_fault;
      fault_code <= next_code;
      // mode and code attributes, read only, no register change
      mode_64 <= in64;
      cs_long <= cs_attr[`SSU_ATTR_LONG];
      cs_dsize <= cs_attr[`SSU_ATTR_DSIZE];
      // access answer, address held back on fault
      acc_done <= acc_valid;
      if (acc_valid) begin
        acc_rpl <= sel_r[acc_seg][`SSU_RPL_HI:`SSU_RPL_LO];
        if (!acc_flt)
          acc_lin <= acc_lin_w;
      end
      // model register answer for any address, read data only from the auxiliary bases
      msr_done <= msr_wr | msr_rd;
      if (msr_rd) begin
        if (msr_hit1 && !msr_priv_bad)
          msr_rdata <= {bhi[`SSU_SEG_AUX1], blo[`SSU_SEG_AUX1]};
        else if (msr_hit2 && !msr_priv_bad)
          msr_rdata <= {bhi[`SSU_SEG_AUX2], blo[`SSU_SEG_AUX2]};
        else
          msr_rdata <= 64'h0000_0000_0000_0000;
      end
      // full 64-bit base written in one step
      if (msr_ok && msr_hit1) begin
        blo[`SSU_SEG_AUX1] <= msr_wdata[31:0];
        bhi[`SSU_SEG_AUX1] <= msr_wdata[63:32];
      end
      if (msr_ok && msr_hit2) begin
        blo[`SSU_SEG_AUX2] <= msr_wdata[31:0];
        bhi[`SSU_SEG_AUX2] <= msr_wdata[63:32];
      end
      // load sequencer
      case (st)
        ST_IDLE: begin
          if (ld_take && !ld_bad) begin
            ld_rpl <= ld_rpl_w;
            if (ld_null) begin
              // null selector kept, no entry fetched
              sel_r[ld_seg] <= ld_sel;
              ld_done <= 1'b1;
            end else begin
              ld_seg_q <= ld_seg;
              ld_sel_q <= ld_sel;
              dsc_req <= 1'b1;
              dsc_addr <= ld_entry;
              ld_busy <= 1'b1;
              st <= ST_FETCH;
            end
          end
        end
        ST_FETCH: begin
          if (dsc_ack) begin
            dsc_req <= 1'b0;
            ld_busy <= 1'b0;
            ld_done <= 1'b1;
            sel_r[ld_seg_q] <= ld_sel_q;
            blo[ld_seg_q] <= dsc_base[31:0];
            // upper base only for the local table pointer in 64-bit mode
            if (ld_seg_q == `SSU_SEG_LTP && in64)
              bhi[ld_seg_q] <= dsc_base[63:32];
            else
              bhi[ld_seg_q] <= 32'h0000_0000;
            lim[ld_seg_q] <= dsc_limit;
            atr[ld_seg_q] <= dsc_attr;
            if (ld_seg_q == `SSU_SEG_CODE)
              cur_cpl <= dsc_attr[`SSU_ATTR_DPL_HI:`SSU_ATTR_DPL_LO];
            st <= ST_IDLE;
          end
        end
        default: begin
          st <= ST_IDLE;
          dsc_req <= 1'b0;
          ld_busy <= 1'b0;
        end
      endcase
    end
  end
endmodule // ssu_top

// [ssu_top_props.sv]
`timescale 1ns/10ps
`include "ssu_consts.vh"
module ssu_top_props (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  // load and fetch
  input wire ld_valid,
  input wire ld_busy,
  input wire ld_done,
  input wire [2:0] ld_seg,
  input wire [15:0] ld_sel,
  input wire [63:0] glob_base,
  input wire dsc_req,
  input wire dsc_ack,
  input wire [63:0] dsc_addr,
  // model registers and faults
  input wire msr_wr,
  input wire msr_rd,
  input wire [31:0] msr_addr,
  input wire [63:0] msr_wdata,
  input wire msr_done,
  input wire [1:0] cur_cpl,
  input wire fault,
  input wire [2:0] fault_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // accepted load, null selector, lone write to an auxiliary base
  wire take = clk_en && ld_valid && !ld_busy;
  wire is_null = ld_sel[15:2] == 14'h0000;
  wire aux_wr = clk_en && msr_wr && !ld_valid && msr_addr[31:1] == 31'h6000_0080;
  wire canon = msr_wdata[63:47] == 17'h0_0000 || msr_wdata[63:47] == 17'h1_ffff;

  a_entry_addr: assert property ($rose(dsc_req) && !$past(ld_sel[2])
    |-> dsc_addr == glob_base + {$past(ld_sel[15:3]), 3'h0}) else $error("bad entry address");
  a_fetch_hold: assert property (dsc_req && !dsc_ack |=> dsc_req && $stable(dsc_addr))
    else $error("fetch dropped");
  a_fetch_done: assert property (clk_en && dsc_req && dsc_ack |=> ld_done && !dsc_req)
    else $error("fetch not closed");
  a_busy_fetch: assert property (ld_busy == dsc_req) else $error("busy mismatch");
  a_null_code: assert property (take && ld_seg == `SSU_SEG_CODE && is_null
    |=> fault && fault_code == `SSU_FLT_NULL_LOAD && !ld_done) else $error("null code taken");
  a_msr_answer: assert property (clk_en && (msr_wr || msr_rd) |=> msr_done)
    else $error("register access lost");
  a_msr_priv: assert property (aux_wr && cur_cpl != 2'h0
    |=> fault && fault_code == `SSU_FLT_MSR_PRIV) else $error("privilege not refused");
  a_msr_canon: assert property (aux_wr && cur_cpl == 2'h0 && !canon
    |=> fault && fault_code == `SSU_FLT_MSR_CANON) else $error("bad base accepted");
  c_fetch: cover property (dsc_req && dsc_ack);
  c_null_load: cover property (take && is_null);
  c_canon: cover property (fault && fault_code == `SSU_FLT_MSR_CANON);
endmodule // ssu_top_props

// [ssu_dsc_model.sv]
`timescale 1ns/10ps
module ssu_dsc_model (
  // clock and attribute to hand back
  input wire clk,
  input wire [15:0] attr,
  // descriptor fetch link
  input wire dsc_req,
  input wire [63:0] dsc_addr,
  output reg dsc_ack,
  output reg [63:0] dsc_base,
  output reg [31:0] dsc_limit,
  output reg [15:0] dsc_attr
);
  reg [1:0] cnt;
  initial {dsc_ack, cnt, dsc_base, dsc_limit, dsc_attr} = '0;
  // wait set by entry address bits 4..3; idle lines flip each cycle
  always @(posedge clk) begin
    dsc_ack <= 1'b0;
    dsc_base <= ~dsc_base;
    dsc_limit <= ~dsc_limit;
    dsc_attr <= ~dsc_attr;
    cnt <= 2'h0;
    if (dsc_req && !dsc_ack && cnt != dsc_addr[4:3])
      cnt <= cnt + 2'h1;
    else if (dsc_req && !dsc_ack) begin
      dsc_ack <= 1'b1;
      dsc_base <= {32'hffff_ffff, dsc_addr[31:0] + 32'h0001_0000};
      dsc_limit <= 32'h0000_0fff;
      dsc_attr <= attr;
    end
  end
endmodule // ssu_dsc_model

// [tb.sv]
`timescale 1ns/10ps
`include "ssu_consts.vh"
module tb;
  // driven inputs
  logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, long_act = 1'b0;
  logic ld_valid = 1'b0, acc_valid = 1'b0, acc_ovr_en = 1'b0, msr_wr = 1'b0, msr_rd = 1'b0;
  logic [1:0] acc_kind = 2'h0;
  logic [2:0] ld_seg = 3'h0, acc_ovr_seg = 3'h0;
  logic [15:0] ld_sel = 16'h0000, attr = 16'h0000;
  logic [31:0] msr_addr = 32'h0000_0000;
  logic [63:0] glob_base = 64'h0010_0000, acc_offset = 64'h0, msr_wdata = 64'h0, la;
  // observed outputs
  wire ld_busy, ld_done, dsc_req, dsc_ack, acc_done, msr_done, mode_64, cs_long, cs_dsize, fault;
  wire [1:0] ld_rpl, acc_rpl, cur_cpl;
  wire [2:0] fault_code;
  wire [15:0] dsc_attr;
  wire [31:0] dsc_limit;
  wire [63:0] dsc_addr, dsc_base, acc_lin, msr_rdata;
  int errors = 0, num_checks = 0;

  ssu_top i_dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .long_act(long_act),
    .ld_valid(ld_valid), .ld_seg(ld_seg), .ld_sel(ld_sel), .ld_busy(ld_busy),
    .ld_done(ld_done), .ld_rpl(ld_rpl), .glob_base(glob_base),
    .dsc_req(dsc_req), .dsc_addr(dsc_addr), .dsc_ack(dsc_ack), .dsc_base(dsc_base),
    .dsc_limit(dsc_limit), .dsc_attr(dsc_attr),
    .acc_valid(acc_valid), .acc_kind(acc_kind), .acc_ovr_en(acc_ovr_en),
    .acc_ovr_seg(acc_ovr_seg), .acc_offset(acc_offset), .acc_done(acc_done),
    .acc_lin(acc_lin), .acc_rpl(acc_rpl),
    .msr_wr(msr_wr), .msr_rd(msr_rd), .msr_addr(msr_addr), .msr_wdata(msr_wdata),
    .msr_done(msr_done), .msr_rdata(msr_rdata),
    .cur_cpl(cur_cpl), .mode_64(mode_64), .cs_long(cs_long), .cs_dsize(cs_dsize),
    .fault(fault), .fault_code(fault_code)
  );
  ssu_dsc_model i_mem (
    .clk(clk), .attr(attr), .dsc_req(dsc_req), .dsc_addr(dsc_addr), .dsc_ack(dsc_ack),
    .dsc_base(dsc_base), .dsc_limit(dsc_limit), .dsc_attr(dsc_attr)
  );
  always #20 clk = ~clk;

  task chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task flt(input [2:0] c);
    chk(fault === (c != 3'h0) && (c == 3'h0 || fault_code === c), "fault report");
  endtask

  task load(input [2:0] s, input [15:0] v);
    int n;
    @(negedge clk);
    ld_valid = 1'b1;
    ld_seg = s;
    ld_sel = v;
    @(negedge clk);
    ld_valid = 1'b0;
    for (n = 0; n < 20 && ld_done !== 1'b1 && fault !== 1'b1; n++) begin
      if (dsc_req === 1'b1)
        la = dsc_addr;
      @(negedge clk);
    end
    chk(n < 20, "load hang");
  endtask

  task acc(input [1:0] k, input [2:0] o, input [63:0] a);
    @(negedge clk);
    acc_valid = 1'b1;
    acc_kind = k;
    acc_ovr_en = o != 3'h0;
    acc_ovr_seg = o;
    acc_offset = a;
    @(negedge clk);
    acc_valid = 1'b0;
    chk(acc_done === 1'b1, "no access answer");
  endtask

  task model_specific_reg(input w, input [31:0] a, input [63:0] d);
    @(negedge clk);
    msr_wr = w;
    msr_rd = !w;
    msr_addr = a;
    msr_wdata = d;
    @(negedge clk);
    msr_wr = 1'b0;
    msr_rd = 1'b0;
    chk(msr_done === 1'b1, "no register answer");
  endtask

  // entry addressing, segment for data, string and stack accesses, limit, local table
  task t_fetch;
    load(3'h3, 16'h0013);
    chk(la === 64'h0010_0010 && ld_rpl === 2'h3, "data load");
    load(3'h0, 16'h0020);
    load(3'h2, 16'h0028);
    for (int k = 1; k < 4; k++) begin
      acc(k[1:0], 3'h0, 64'h0);
      chk(acc_lin === 64'h0011_0010 + 64'(8 * k * (k > 1)), "segment choice");
      chk(acc_rpl === (k == 1 ? 2'h3 : 2'h0), "selector privilege");
    end
    acc(2'h1, 3'h0, 64'h1000);
    flt(3'h3);
    chk(acc_lin === 64'h0011_0028, "lin kept");
    load(3'h6, 16'h0030);
    load(3'h3, 16'h000c);
    chk(la === 64'h0011_0038, "local entry");
  endtask

  // null selectors, out-of-range segment code
  task t_null;
    load(3'h3, 16'h0003);
    chk(ld_done === 1'b1 && fault === 1'b0, "null data load");
    acc(2'h1, 3'h0, 64'h0);
    flt(3'h2);
    load(3'h1, 16'h0000);
    flt(3'h1);
    load(3'h2, 16'h0001);
    flt(3'h1);
    load(3'h7, 16'h0008);
    flt(3'h1);
  endtask

  // code privilege and flat 64-bit addressing
  task t_code;
    attr = 16'h6040;
    load(3'h1, 16'h0008);
    // attribute outputs follow the stored code entry one cycle later
    @(negedge clk);
    chk(cur_cpl === 2'h2 && cs_long === 1'b1 && cs_dsize === 1'b1, "code load");
    long_act = 1'b1;
    acc(2'h0, 3'h0, 64'h1234);
    chk(mode_64 === 1'b1 && acc_lin === 64'h1234 && fault === 1'b0, "flat fetch");
    acc(2'h1, 3'h0, 64'h0000_8000_0000_0000);
    flt(3'h4);
    load(3'h2, 16'h0000);
    flt(3'h0);
    acc(2'h3, 3'h0, 64'h0040);
    chk(acc_lin === 64'h0040 && fault === 1'b0, "flat stack");
    long_act = 1'b0;
    acc(2'h1, 3'h0, 64'h0);
    flt(3'h2);
  endtask

  // auxiliary bases
  task t_aux;
    model_specific_reg(1'b1, `SSU_MSR_AUX1, 64'h0);
    flt(3'h5);
    attr = 16'h0000;
    load(3'h1, 16'h0008);
    load(3'h4, 16'h0040);
    model_specific_reg(1'b0, `SSU_MSR_AUX1, 64'h0);
    chk(msr_rdata === 64'h0011_0040, "load base");
    model_specific_reg(1'b1, `SSU_MSR_AUX1, 64'hffff_8000_0000_1000);
    flt(3'h0);
    model_specific_reg(1'b1, `SSU_MSR_AUX2, 64'h0001_0000_0000_0000);
    flt(3'h6);
    model_specific_reg(1'b0, `SSU_MSR_AUX2, 64'h0);
    chk(msr_rdata === 64'h0, "refused write");
    model_specific_reg(1'b0, 32'hc000_0102, 64'h0);
    chk(msr_rdata === 64'h0 && fault === 1'b0, "unmapped read");
    long_act = 1'b1;
    acc(2'h1, 3'h4, 64'h0010);
    chk(acc_lin === 64'h1010 && fault === 1'b0, "compat base");
    attr = 16'h2000;
    load(3'h1, 16'h0008);
    acc(2'h1, 3'h4, 64'h0000_7fff_ffff_f000);
    chk(acc_lin === 64'h0 && fault === 1'b0, "wrapped sum");
    acc(2'h1, 3'h4, 64'h8000_0000_0000_0000);
    flt(3'h4);
    load(3'h3, 16'h0018);
    chk(la === 64'h0010_0018, "long mode entry");
    load(3'h6, 16'h0030);
    load(3'h0, 16'h0004);
    chk(la === 64'hffff_ffff_0011_0030, "wide local base");
    long_act = 1'b0;
    load(3'h0, 16'h0004);
    chk(la === 64'h0000_0000_0011_0030, "upper base dropped");
  endtask

  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // reset, then scenarios
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    t_fetch;
    t_null;
    t_code;
    t_aux;
    report_and_stop;
  end

  // hang guard
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
endmodule // tb

bind ssu_top ssu_top_props i_props (
  .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .ld_valid(ld_valid), .ld_busy(ld_busy), .ld_done(ld_done), .ld_seg(ld_seg),
  .ld_sel(ld_sel), .glob_base(glob_base),
  .dsc_req(dsc_req), .dsc_ack(dsc_ack), .dsc_addr(dsc_addr),
  .msr_wr(msr_wr), .msr_rd(msr_rd), .msr_addr(msr_addr), .msr_wdata(msr_wdata),
  .msr_done(msr_done), .cur_cpl(cur_cpl), .fault(fault), .fault_code(fault_code)
);
